/* design/pwlock_params.svh */
// constants of the password lock: register offsets, field positions, reset values
// assumes a 32-bit axi4-lite slave port, one aligned word per register
`ifndef PWLOCK_PARAMS_SVH
`define PWLOCK_PARAMS_SVH
`define OFS_CTRL        4'h0
`define OFS_CODE        4'h4
`define OFS_SCOPE       4'h8
`define OFS_STATUS      4'hC
`define CMD_STORE       0
`define CMD_ACTIVATE    1
`define CMD_UNLOCK      2
`define CMD_ANS_CANCEL  3
`define CMD_ANS_ERASE   4
`define CMD_CARD_LOAD   5
`define CMD_RUNSTOP     6
`define CMD_CLOCKSET    7
`define CMD_MENU        8
`define CMD_NOCODE      9
`define SC_PROGRAM      0
`define SC_PARAM        1
`define SC_CLOCK        2
`define SC_OPMODE       3
`define SC_IFACE        4
`define SC_ERASEDIS     5
`define SCOPE_W         6
`define SCOPE_RST       6'h01
`define CODE_RST        16'h0000
`define WRONG_LIMIT     3'h4
`define WRONG_W         3
`define DIGIT_MAX       4'h9
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

/* design/pwlock_pkg.sv */
// types shared by the password lock
// assumes pwlock_params.svh supplies the widths
`include "pwlock_params.svh"
package pwlock_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRSP = 2'b01,
    BUS_RRSP = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [15:0]          code;
    logic [`SCOPE_W-1:0]  scope;
    logic                 present;
    logic                 active;
    logic [`WRONG_W-1:0]  wrong;
    logic                 prompt;
    logic                 runMode;
    logic                 erasePulse;
    logic                 refused;
    logic                 awGot;
    logic                 wGot;
    logic [3:0]           awAddr;
    logic [31:0]          wData;
    logic [3:0]           wStrb;
    bus_state_t           bus;
    logic [1:0]           resp;
    logic [31:0]          rData;
  } lock_state_t;

  typedef struct packed {
    logic [15:0]          code;
    logic [`SCOPE_W-1:0]  scope;
    logic                 present;
  } card_image_t;
endpackage : pwlock_pkg

/* design/password_lock.sv */
// password lock controller: stored bcd code, protection scope, active flag, erase prompt
// assumes an axi4-lite master on mclk and a memory card controller on card ports
//
// Notes on behaviour
// - only four bcd digits 0001 to 9999 form a valid password
// - storing 0000 removes the password, present flag clears
// - reset gives code 0000, none present, none active, program scope selected
// - system menu is always protected while a password is active
// - password can be stored in run or stop state alike
// - storing a password leaves protection inactive until activated
// - each digit position is set separately to a value 0 to 9
// - scope mask can never be empty; clearing the last bit is refused
// - default scope protects program, diagram and non-enabled parameters
// - run/stop toggling refused when opmode scope set and active
// - date and time changes refused when clock scope set and active
// - programming interface blocked when interface scope set and active
// - four wrong entries raise erase prompt unless prompt disable bit set
// - present password activates at power-up, on card load, on activate command; here reset clears present and active
// - correct password needed before protected function or system menu is given
// - matching entry deactivates protection and returns to status view
// - writing a program to the card carries the stored password with it
// - loading a card program with password adopts it and activates at once
// - cancel keeps all and allows four more tries; confirm erases all
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pwlock_params.svh"
module password_lock
  import pwlock_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // axi4-lite write address
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // memory card image
  output card_image_t      cardOut,
  input  card_image_t      cardIn,
  // access gates
  output logic             lockActive,
  output logic             menuBlocked,
  output logic             ifaceBlocked,
  output logic             erasePrompt,
  output logic             eraseAll
);

  lock_state_t stateFf;
  lock_state_t nxtState;

  // digit check kept as a function; the same test guards store and unlock
  function automatic logic digitsOk(input logic [15:0] c);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (c[4*i +: 4] > `DIGIT_MAX)
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : digitsOk

  logic        wrFire;
  logic        rdFire;
  logic [31:0] wVal;
  logic [3:0]  wAdr;
  logic [15:0] entry;
  logic        entryOk;

  assign awready = (stateFf.bus == BUS_IDLE) && !stateFf.awGot && !arvalid;
  assign wready  = (stateFf.bus == BUS_IDLE) && !stateFf.wGot && !arvalid;
  assign arready = (stateFf.bus == BUS_IDLE) && !stateFf.awGot && !stateFf.wGot;
  assign bvalid  = (stateFf.bus == BUS_WRSP);
  assign rvalid  = (stateFf.bus == BUS_RRSP);
  assign bresp   = stateFf.resp;
  assign rresp   = stateFf.resp;
  assign rdata   = stateFf.rData;

  assign lockActive   = stateFf.active;
  assign menuBlocked  = stateFf.active;
  assign ifaceBlocked = stateFf.active && stateFf.scope[`SC_IFACE];
  assign erasePrompt  = stateFf.prompt;
  assign eraseAll     = stateFf.erasePulse;
  assign cardOut.code    = stateFf.code;
  assign cardOut.scope   = stateFf.scope;
  assign cardOut.present = stateFf.present;

  always_comb
  begin
    nxtState = stateFf;
    nxtState.erasePulse = 1'b0;
    wrFire = 1'b0;
    rdFire = 1'b0;
    wAdr   = stateFf.awGot ? stateFf.awAddr : awaddr;
    wVal   = stateFf.wGot ? stateFf.wData : wdata;
    entry  = wVal[31:16];
    entryOk = digitsOk(entry);
    case (stateFf.bus)
      BUS_IDLE:
      begin
        if (awvalid && awready)
        begin
          nxtState.awGot  = 1'b1;
          nxtState.awAddr = awaddr;
        end
        if (wvalid && wready)
        begin
          nxtState.wGot  = 1'b1;
          nxtState.wData = wdata;
          nxtState.wStrb = wstrb;
        end
        if ((stateFf.awGot || (awvalid && awready)) && (stateFf.wGot || (wvalid && wready)))
        begin
          wrFire = 1'b1;
          nxtState.awGot = 1'b0;
          nxtState.wGot  = 1'b0;
          nxtState.bus   = BUS_WRSP;
          nxtState.resp  = `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
          rdFire = 1'b1;
          nxtState.bus  = BUS_RRSP;
          nxtState.resp = `RESP_OKAY;
          case (araddr)
            `OFS_CTRL:   nxtState.rData = {31'h0, stateFf.runMode};
            `OFS_CODE:   nxtState.rData = {16'h0, stateFf.code};
            `OFS_SCOPE:  nxtState.rData = {26'h0, stateFf.scope};
            `OFS_STATUS: nxtState.rData = {25'h0, stateFf.refused, stateFf.prompt,
                                           stateFf.wrong, stateFf.active, stateFf.present};
            default:
            begin
              nxtState.rData = 32'h0;
              nxtState.resp  = `RESP_SLVERR;
            end
          endcase
        end
      end
      BUS_WRSP:
      begin
        if (bready)
        begin
          nxtState.bus = BUS_IDLE;
        end
      end
      BUS_RRSP:
      begin
        if (rready)
        begin
          nxtState.bus = BUS_IDLE;
        end
      end
      default:
      begin
        nxtState.bus = BUS_IDLE;
      end
    endcase

    // card load adopts the password and locks at once
    if (cardIn.present && wrFire && wAdr == `OFS_CTRL && wVal[`CMD_CARD_LOAD])
    begin
      nxtState.code    = cardIn.code;
      nxtState.scope   = (cardIn.scope == '0) ? `SCOPE_RST : cardIn.scope;
      nxtState.present = 1'b1;
      nxtState.active  = 1'b1;
    end
    else if (wrFire && wAdr == `OFS_CTRL)
    begin
      nxtState.refused = 1'b0;
      if (wVal[`CMD_STORE])
      begin
        // stored in either run mode; menu must be open to reach it
        if (!stateFf.active && entryOk)
        begin
          nxtState.code    = entry;
          nxtState.present = (entry != 16'h0000);
          nxtState.active  = 1'b0;
        end
        else
        begin
          nxtState.refused = 1'b1;
        end
      end
      if (wVal[`CMD_ACTIVATE] && stateFf.present)
      begin
        nxtState.active = 1'b1;
      end
      if (wVal[`CMD_UNLOCK] && stateFf.active && !stateFf.prompt)
      begin
        if (entryOk && entry == stateFf.code)
        begin
          nxtState.active = 1'b0;
          nxtState.wrong  = '0;
        end
        else if (stateFf.wrong == `WRONG_LIMIT - 3'h1)
        begin
          nxtState.wrong  = `WRONG_LIMIT;
          nxtState.prompt = !stateFf.scope[`SC_ERASEDIS];
        end
        else if (stateFf.wrong != `WRONG_LIMIT || !stateFf.scope[`SC_ERASEDIS])
        begin
          nxtState.wrong = stateFf.wrong + 3'h1;
        end
      end
      if (stateFf.prompt && wVal[`CMD_ANS_CANCEL])
      begin
        nxtState.prompt = 1'b0;
        nxtState.wrong  = '0;
      end
      else if (stateFf.prompt && wVal[`CMD_ANS_ERASE])
      begin
        nxtState.prompt     = 1'b0;
        nxtState.wrong      = '0;
        nxtState.code       = `CODE_RST;
        nxtState.present    = 1'b0;
        nxtState.active     = 1'b0;
        nxtState.erasePulse = 1'b1;
      end
      if (wVal[`CMD_RUNSTOP])
      begin
        if (stateFf.active && stateFf.scope[`SC_OPMODE])
        begin
          nxtState.refused = 1'b1;
        end
        else
        begin
          nxtState.runMode = !stateFf.runMode;
        end
      end
      if (wVal[`CMD_CLOCKSET] && stateFf.active && stateFf.scope[`SC_CLOCK])
      begin
        nxtState.refused = 1'b1;
      end
      if (wVal[`CMD_MENU] && stateFf.active)
      begin
        nxtState.refused = 1'b1;
      end
    end
    else if (wrFire && wAdr == `OFS_SCOPE)
    begin
      if (stateFf.active || wVal[`SCOPE_W-1:0] == '0)
      begin
        nxtState.refused = 1'b1;
      end
      else
      begin
        nxtState.scope   = wVal[`SCOPE_W-1:0];
        nxtState.refused = 1'b0;
      end
    end
    else if (wrFire && wAdr != `OFS_CODE)
    begin
      nxtState.resp = `RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      // retained fields modelled by reset defaults; reset clears both active and present
      stateFf         <= '0;
      stateFf.code    <= `CODE_RST;
      stateFf.scope   <= `SCOPE_RST;
      stateFf.bus     <= BUS_IDLE;
    end
    else
    begin
      stateFf <= nxtState;
    end
  end

endmodule : password_lock

/* tb/pwlock_checker.sv */
// port assertions for password_lock
// assumes bind into password_lock, single mclk domain
`timescale 1ns/10ps
`include "pwlock_params.svh"
module pwlock_checker
  import pwlock_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // lock state
  input wire card_image_t cardOut,
  input wire logic        lockActive,
  input wire logic        menuBlocked,
  input wire logic        ifaceBlocked,
  input wire logic        erasePrompt,
  input wire logic        eraseAll
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence wiped_s;
    !lockActive && !cardOut.present && cardOut.code == 16'h0000;
  endsequence
  menu_gate_a: assert property (menuBlocked == lockActive)
    else $error("menu gate wrong");
  iface_gate_a: assert property (
    ifaceBlocked == (lockActive && cardOut.scope[`SC_IFACE])) else $error("iface gate wrong");
  scope_kept_a: assert property (cardOut.scope != 6'h00)
    else $error("scope empty");
  digit_range_a: assert property (cardOut.code[15:12] <= `DIGIT_MAX &&
    cardOut.code[11:8] <= `DIGIT_MAX && cardOut.code[7:4] <= `DIGIT_MAX &&
    cardOut.code[3:0] <= `DIGIT_MAX) else $error("code digit above nine");
  code_present_a: assert property (cardOut.present |-> cardOut.code != 16'h0000)
    else $error("present with zero code");
  lock_present_a: assert property (lockActive |-> cardOut.present)
    else $error("lock without password");
  prompt_gate_a: assert property (
    erasePrompt |-> lockActive && !cardOut.scope[`SC_ERASEDIS]) else $error("prompt wrong");
  erase_end_a: assert property (
    eraseAll |-> $past(erasePrompt) ##0 wiped_s ##1 !eraseAll) else $error("erase wrong");
endmodule : pwlock_checker
bind password_lock pwlock_checker u_pwlock_checker (.mclk(mclk), .resetn(resetn),
  .cardOut(cardOut), .lockActive(lockActive), .menuBlocked(menuBlocked),
  .ifaceBlocked(ifaceBlocked), .erasePrompt(erasePrompt), .eraseAll(eraseAll));

/* tb/card_model.sv */
// memory card partner: offers one stored program image
// assumes the lock samples cardIn only on its card load command
`timescale 1ns/10ps
module card_model
  import pwlock_pkg::*;
#(
  parameter card_image_t IMAGE = {16'h0042, 6'h21, 1'b1}
)
(
  // image written by the lock
  input  wire card_image_t cardOut,
  // image offered for loading
  output card_image_t      cardIn
);
  // image carries a password, so loading it must lock at once
  assign cardIn = IMAGE;
endmodule : card_model

/* tb/tb.sv */
// self-checking bench for password_lock over axi4-lite
// assumes card_model image 0042 scope 21, checker bound beside
`timescale 1ns/10ps
`include "pwlock_params.svh"
module tb import pwlock_pkg::*;
;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, dat;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic        lockActive, menuBlocked, ifaceBlocked, erasePrompt, eraseAll;
  card_image_t cardOut, cardIn;
  int          errors = 0;
  int          checks = 0;
  always #5 mclk = ~mclk;
  // bready and rready held high: answers are always welcome
  password_lock u_password_lock (.mclk(mclk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(1'b1), .cardOut(cardOut), .cardIn(cardIn), .lockActive(lockActive),
    .menuBlocked(menuBlocked), .ifaceBlocked(ifaceBlocked), .erasePrompt(erasePrompt),
    .eraseAll(eraseAll));
  card_model u_card_model (.cardOut(cardOut), .cardIn(cardIn));
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // handshakes sampled at the rising edge that moves them, released just after it
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    r = 2'h0;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        return;
      end
    end
    errors++;
    conclude();
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    d = 32'h0;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        return;
      end
    end
    errors++;
    conclude();
  endtask : rd
  task automatic ex(input logic [3:0] a, input logic [31:0] e, input string nm);
    rd(a, dat);
    chk(nm, dat, e);
  endtask : ex
  task automatic st(input logic [5:0] e, input string nm);
    rd(`OFS_STATUS, dat);
    chk(nm, dat & 32'h0000003F, {26'h0, e});
  endtask : st
  task automatic cmd(input int b, input logic [15:0] c);
    wr(`OFS_CTRL, {c, 16'h0001 << b}, rsp);
  endtask : cmd
  task automatic wrong4(input logic dis);
    for (int i = 1; i <= 4; i++)
    begin
      cmd(`CMD_UNLOCK, 16'h9999);
      st({(i == 4 && !dis), 3'(i), 2'b11}, "wrong count");
    end
  endtask : wrong4
  initial
  begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    st(6'h00, "status at reset");
    ex(`OFS_SCOPE, 32'h1, "scope at reset");
    ex(`OFS_CODE, 32'h0, "code at reset");
    wr(4'h2, 32'h0, rsp);
    chk("unmapped write", rsp, `RESP_SLVERR);
    ex(4'h2, 32'h0, "unmapped read");
    cmd(`CMD_RUNSTOP, 16'h0);
    ex(`OFS_CTRL, 32'h1, "run mode");
    cmd(`CMD_STORE, 16'h12A4);
    ex(`OFS_CODE, 32'h0, "non bcd code");
    cmd(`CMD_STORE, 16'h1789);
    ex(`OFS_CODE, 32'h1789, "code stored in run");
    st(6'h01, "stored inactive");
    wr(`OFS_SCOPE, 32'h0, rsp);
    ex(`OFS_SCOPE, 32'h1, "empty scope");
    wr(`OFS_SCOPE, 32'h1C, rsp);
    cmd(`CMD_ACTIVATE, 16'h0);
    chk("gates", {ifaceBlocked, menuBlocked}, 2'b11);
    cmd(`CMD_RUNSTOP, 16'h0);
    ex(`OFS_STATUS, 32'h43, "runstop refused");
    ex(`OFS_CTRL, 32'h1, "run mode kept");
    cmd(`CMD_MENU, 16'h0);
    ex(`OFS_STATUS, 32'h43, "menu refused");
    cmd(`CMD_CLOCKSET, 16'h0);
    ex(`OFS_STATUS, 32'h43, "clock refused");
    wr(`OFS_SCOPE, 32'h3F, rsp);
    ex(`OFS_SCOPE, 32'h1C, "scope locked");
    wrong4(1'b0);
    chk("prompt pin", erasePrompt, 32'h1);
    cmd(`CMD_ANS_CANCEL, 16'h0);
    st(6'h03, "cancel keeps");
    cmd(`CMD_UNLOCK, 16'h1789);
    st(6'h01, "unlocked");
    chk("card image", cardOut, {16'h1789, 6'h1C, 1'b1});
    chk("lock pin", lockActive, 32'h0);
    cmd(`CMD_STORE, 16'h0);
    st(6'h00, "password removed");
    cmd(`CMD_CARD_LOAD, 16'h0);
    ex(`OFS_CODE, 32'h42, "card code");
    st(6'h03, "card load locks");
    wrong4(1'b1);
    cmd(`CMD_UNLOCK, 16'h0042);
    wr(`OFS_SCOPE, 32'h1, rsp);
    cmd(`CMD_ACTIVATE, 16'h0);
    wrong4(1'b0);
    cmd(`CMD_ANS_ERASE, 16'h0);
    st(6'h00, "erased");
    ex(`OFS_CODE, 32'h0, "code erased");
    conclude();
  end
endmodule : tb
